// >>> sac_ctrl.sv
// Simultaneous-sampling converter control with AHB-Lite register access
//
// Behaviour
// - span pin high selects 10 V bipolar span, low selects 5 V.
// - start rising edge puts all eight track-and-holds into hold together.
// - eight channels converted on internal clock in 4 us; then busy falls.
// - busy falling returns every track-and-hold to track mode.
// - new results readable after busy falls; old set stays during busy.
// - results are 18-bit twos complement, step is span over 262144.
// - code scaling uses 20 V span wide, 10 V span narrow.
// - max input 0x1FFFF, zero 0x00000, minus one 0x3FFFF, min 0x20000.
// - reference pin high enables internal reference, low needs external.
// - at reset release the reference mode is taken from the reference select pin and held until a reload.
// - busy rises on start rising edge and stays high until done.
`timescale 1ns/1ps
`include "sac_defines.svh"
module sac_ctrl #(
  parameter int CONV_CYC = `SAC_CONV_CYC,
  parameter int CHANNELS = `SAC_NUM_CH
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Pins
  input wire logic conversion_start_in,
  input wire logic span_sel_in,
  input wire logic ref_sel_in,
  // Analog core
  input wire logic [17:0] adc_raw_in,
  output logic [2:0] chan_sel_out,
  output logic hold_out,
  output logic busy_out,
  output sac_pkg::sac_cfg_t cfg_out,
  output logic reference_io_pin_oe_out,
  output logic irq_out
);
  import sac_pkg::*;

  localparam int CONV_CYC_I = CONV_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] start_sync_r;
  logic [1:0] span_sync_r;
  logic [1:0] ref_sync_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      start_sync_r <= 3'h0;
    end else begin
      start_sync_r <= {start_sync_r[1:0], conversion_start_in};
    end
  end

  // Level pins keep sampling under reset so the release edge sees them settled
  always_ff @(posedge clock_in) begin
    span_sync_r <= {span_sync_r[0], span_sel_in};
    ref_sync_r <= {ref_sync_r[0], ref_sel_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase

  logic acc;
  logic mapped;
  logic [3:0] idx;
  logic a_valid_r;
  logic a_write_r;
  logic [3:0] a_idx_r;
  logic wr_en;
  logic rd_acc;

  assign acc = hsel_in && htrans_in[1] && hready_in;
  assign idx = haddr_in[5:2];
  assign mapped = (haddr_in[31:6] == 26'h0) && (idx < 4'(`SAC_NUM_REGS));
  assign rd_acc = acc && !hwrite_in && mapped;
  assign wr_en = a_valid_r && a_write_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      a_valid_r <= 1'b0;
      a_write_r <= 1'b0;
      a_idx_r <= 4'h0;
    end else begin
      a_valid_r <= acc && mapped;
      a_write_r <= hwrite_in;
      a_idx_r <= idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control writes

  logic soft_start_r;
  logic reload_r;
  logic [`SAC_INT_W-1:0] mask_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      soft_start_r <= 1'b0;
      reload_r <= 1'b0;
    end else begin
      soft_start_r <= wr_en && (a_idx_r == 4'(`SAC_OFS_CTRL >> 2))
                      && hwdata_in[`SAC_CTRL_START];
      reload_r <= wr_en && (a_idx_r == 4'(`SAC_OFS_CTRL >> 2))
                  && hwdata_in[`SAC_CTRL_RELOAD];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mask_r <= `SAC_INT_MASK_RST;
    end else if (wr_en && (a_idx_r == 4'(`SAC_OFS_INT_MASK >> 2))) begin
      mask_r <= hwdata_in[`SAC_INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture

  logic out_of_reset_r;
  logic cfg_load;
  sac_cfg_t cfg_r;

  // Pins are caught after release, never under reset, so the reset stays clean
  assign cfg_load = !out_of_reset_r || reload_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      out_of_reset_r <= 1'b0;
    end else begin
      out_of_reset_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cfg_r <= '0;
    end else if (cfg_load) begin
      cfg_r.span_10v <= span_sync_r[1];
      cfg_r.int_ref <= ref_sync_r[1];
    end
  end

  assign cfg_out = cfg_r;
  assign reference_io_pin_oe_out = cfg_r.int_ref;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequence

  logic start_edge;
  logic start_ok;
  logic seq_busy;
  logic seq_cap;
  logic seq_done;
  logic [2:0] seq_chan;
  logic hold_r;

  assign start_edge = (start_sync_r[1] && !start_sync_r[2]) || soft_start_r;
  // Starts during a conversion are dropped so held samples are not disturbed
  assign start_ok = start_edge && !seq_busy;

  sac_seq #(
    .CONV_CYC(CONV_CYC),
    .CHANNELS(CHANNELS)
  ) u_seq (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .start_in(start_ok),
    .busy_out(seq_busy),
    .chan_out(seq_chan),
    .cap_out(seq_cap),
    .done_out(seq_done)
  );

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      hold_r <= 1'b0;
    end else if (start_ok) begin
      hold_r <= 1'b1;
    end else if (seq_done) begin
      hold_r <= 1'b0;
    end
  end

  assign hold_out = hold_r;
  assign busy_out = seq_busy;
  assign chan_sel_out = seq_chan;

  ////////////////////////////////////////////////////////////////////////////
  // Results

  logic [17:0] shadow_r [CHANNELS];
  logic [17:0] res_r [CHANNELS];

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < CHANNELS; i++) begin
        shadow_r[i] <= `SAC_CODE_ZERO;
      end
    end else if (seq_cap) begin
      shadow_r[seq_chan] <= sac_to_twos(adc_raw_in);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < CHANNELS; i++) begin
        res_r[i] <= `SAC_CODE_ZERO;
      end
    end else if (seq_done) begin
      for (int i = 0; i < CHANNELS; i++) begin
        res_r[i] <= (seq_chan == 3'(i)) ? sac_to_twos(adc_raw_in) : shadow_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [`SAC_INT_W-1:0] int_stat_r;
  logic [`SAC_INT_W-1:0] int_evt;
  logic int_clr;

  assign int_evt = {start_edge && seq_busy, seq_done};
  assign int_clr = rd_acc && (idx == 4'(`SAC_OFS_INT_STAT >> 2));

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_clr ? '0 : int_stat_r) | int_evt;
    end
  end

  assign irq_out = |(int_stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;

  always_comb begin
    rd_mux = 32'h0;
    case (idx)
      4'(`SAC_OFS_CTRL >> 2): rd_mux = 32'h0;
      4'(`SAC_OFS_STATUS >> 2): begin
        rd_mux[`SAC_STAT_BUSY] = seq_busy;
        rd_mux[`SAC_STAT_SPAN] = cfg_r.span_10v;
        rd_mux[`SAC_STAT_IREF] = cfg_r.int_ref;
        rd_mux[`SAC_STAT_HOLD] = hold_r;
      end
      4'(`SAC_OFS_INT_STAT >> 2): rd_mux[`SAC_INT_W-1:0] = int_stat_r;
      4'(`SAC_OFS_INT_MASK >> 2): rd_mux[`SAC_INT_W-1:0] = mask_r;
      default: begin
        if (idx >= 4'(`SAC_OFS_RESULT0 >> 2)) begin
          rd_mux[17:0] = res_r[3'(idx - 4'(`SAC_OFS_RESULT0 >> 2))];
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      hrdata_r <= 32'h0;
    end else if (rd_acc) begin
      hrdata_r <= rd_mux;
    end else if (acc) begin
      hrdata_r <= 32'h0;
    end
  end

  assign hrdata_out = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] busy_len_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      busy_len_r <= 16'h0;
    end else if (seq_busy) begin
      busy_len_r <= busy_len_r + 16'h1;
    end else begin
      busy_len_r <= 16'h0;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_hold_on_start: assert property (
    start_ok |=> hold_r && seq_busy
  ) else $error("hold not entered after start");

  chk_busy_rises: assert property (
    start_ok |=> seq_busy ##1 seq_busy
  ) else $error("busy did not rise and stay after start");

  chk_busy_length: assert property (
    $fell(seq_busy) |-> busy_len_r == 16'(CONV_CYC_I)
  ) else $error("conversion length wrong");

  chk_track_on_fall: assert property (
    $fell(seq_busy) |-> !hold_r && $past(hold_r)
  ) else $error("track mode not restored at busy fall");

  chk_results_kept: assert property (
    seq_busy && !seq_done |=> res_r[0] == $past(res_r[0])
  ) else $error("results changed during conversion");

  chk_results_load: assert property (
    seq_done && seq_chan != 3'h0 |=> res_r[0] == $past(shadow_r[0])
  ) else $error("results not loaded at busy fall");

  chk_code_max: assert property (
    seq_cap && adc_raw_in == 18'h3FFFF |=> shadow_r[$past(seq_chan)] == `SAC_CODE_MAX
  ) else $error("positive full scale code wrong");

  chk_code_min: assert property (
    seq_cap && adc_raw_in == 18'h0 |=> shadow_r[$past(seq_chan)] == `SAC_CODE_MIN
  ) else $error("negative full scale code wrong");

  chk_span_cfg: assert property (
    cfg_load |=> cfg_r.span_10v == $past(span_sync_r[1])
  ) else $error("span not taken from pin");

  chk_ref_cfg: assert property (
    cfg_load |=> cfg_r.int_ref == $past(ref_sync_r[1]) ##0 reference_io_pin_oe_out == cfg_r.int_ref
  ) else $error("reference mode not taken from pin");

  chk_irq_level: assert property (
    seq_done && mask_r[`SAC_INT_DONE] |=> irq_out
  ) else $error("done interrupt not raised");

endmodule : sac_ctrl

// >>> sac_defines.svh
// Constants for the simultaneous converter control block
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Timing
`define SAC_CLK_PERIOD_NS 20
`define SAC_TCONV_NS 4000
`define SAC_CONV_CYC (`SAC_TCONV_NS / `SAC_CLK_PERIOD_NS)

// Geometry
`define SAC_NUM_CH 8
`define SAC_CODE_W 18

// Code landmarks
`define SAC_CODE_MAX 18'h1FFFF
`define SAC_CODE_ZERO 18'h00000
`define SAC_CODE_M1 18'h3FFFF
`define SAC_CODE_MIN 18'h20000

// Register byte offsets
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_STATUS 8'h04
`define SAC_OFS_INT_STAT 8'h08
`define SAC_OFS_INT_MASK 8'h0C
`define SAC_OFS_RESULT0 8'h10
`define SAC_NUM_REGS 12

// Control bits
`define SAC_CTRL_START 0
`define SAC_CTRL_RELOAD 1

// Status bits
`define SAC_STAT_BUSY 0
`define SAC_STAT_SPAN 1
`define SAC_STAT_IREF 2
`define SAC_STAT_HOLD 3

// Interrupt bits
`define SAC_INT_DONE 0
`define SAC_INT_OVR 1
`define SAC_INT_W 2
`define SAC_INT_MASK_RST 2'h0

`endif

// >>> sac_far_model.sv
// Far-side model: start pin pulser and analog core code source
`timescale 1ns/1ps
module sac_far_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic go_in,
  input wire logic hold_in,
  input wire logic [2:0] chan_in,
  output logic conversion_start_out,
  output logic [17:0] adc_raw_out
);
  logic [17:0] tbl [8] = '{18'h3FFFF, 18'h20000, 18'h1FFFF, 18'h00000,
                           18'h2ABCD, 18'h15555, 18'h3000F, 18'h0FFF0};
  logic [3:0] cnt_r;
  logic hold_q_r;
  logic flip_r;
  // Alternate sets are inverted so an old result differs from a new one
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      hold_q_r <= 1'b0;
      flip_r <= 1'b0;
    end else begin
      hold_q_r <= hold_in;
      flip_r <= flip_r ^ (hold_q_r && !hold_in);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // clean start edge
  // Pulse is long enough to pass the pin synchroniser
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_r <= 4'h0;
    end else if (go_in) begin
      cnt_r <= 4'hF;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign conversion_start_out = (cnt_r != 4'h0);
  // Outside hold the code is inverted, so a stray capture shows up
  assign adc_raw_out = (hold_in ? tbl[chan_in] : ~tbl[chan_in]) ^ {18{flip_r}};
endmodule : sac_far_model

// >>> sac_pkg.sv
// Types shared by the converter control block
package sac_pkg;

  typedef struct packed {
    logic span_10v;
    logic int_ref;
  } sac_cfg_t;

  typedef enum logic [0:0] {
    SAC_IDLE = 1'b0,
    SAC_CONV = 1'b1
  } sac_seq_state_t;

  // Core delivers offset binary; flipping the top bit gives twos complement
  function automatic logic [17:0] sac_to_twos(input logic [17:0] raw);
    sac_to_twos = {~raw[17], raw[16:0]};
  endfunction : sac_to_twos

endpackage : sac_pkg

// >>> sac_seq.sv
// Channel sequencer driven by the internal conversion clock
`timescale 1ns/1ps
module sac_seq #(
  parameter int CONV_CYC = 200,
  parameter int CHANNELS = 8
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  output logic busy_out,
  output logic [2:0] chan_out,
  output logic cap_out,
  output logic done_out
);
  import sac_pkg::*;

  localparam int CH_CYC = CONV_CYC / CHANNELS;

  sac_seq_state_t state_r;
  logic [7:0] cyc_r;
  logic [2:0] chan_r;
  logic slot_end;

  assign slot_end = (state_r == SAC_CONV) && (cyc_r == 8'(CH_CYC - 1));
  assign cap_out = slot_end;
  assign done_out = slot_end && (chan_r == 3'(CHANNELS - 1));
  assign busy_out = (state_r == SAC_CONV);
  assign chan_out = chan_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_r <= SAC_IDLE;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          if (start_in) begin
            state_r <= SAC_CONV;
          end
        end
        SAC_CONV: begin
          if (done_out) begin
            state_r <= SAC_IDLE;
          end
        end
        default: state_r <= SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cyc_r <= 8'h00;
      chan_r <= 3'h0;
    end else if (state_r != SAC_CONV) begin
      cyc_r <= 8'h00;
      chan_r <= 3'h0;
    end else if (slot_end) begin
      cyc_r <= 8'h00;
      chan_r <= chan_r + 3'h1;
    end else begin
      cyc_r <= cyc_r + 8'h01;
    end
  end

endmodule : sac_seq

// >>> tb_simultaneous_adc_conversion_control.sv
// Testbench for the converter control block
`timescale 1ns/1ps
module tb_simultaneous_adc_conversion_control;
  import sac_pkg::*;
  localparam int CONV = 16;
  logic clock_in = 1'b0, reset_n_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic span_sel = 1'b1, ref_sel = 1'b0, go = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, busy, hold, oe, irq, cstart;
  logic [2:0] chan;
  logic [17:0] raw;
  sac_cfg_t cfg;
  int n_errors = 0, tests_run = 0, cyc = 0, n;
  logic [17:0] expv [8] = '{18'h1FFFF, 18'h00000, 18'h3FFFF, 18'h20000,
                            18'h0ABCD, 18'h35555, 18'h1000F, 18'h2FFF0};

  always #10 clock_in = ~clock_in;

  sac_ctrl #(.CONV_CYC(CONV), .CHANNELS(8)) dut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .conversion_start_in(cstart), .span_sel_in(span_sel), .ref_sel_in(ref_sel),
    .adc_raw_in(raw), .chan_sel_out(chan), .hold_out(hold), .busy_out(busy),
    .cfg_out(cfg), .reference_io_pin_oe_out(oe), .irq_out(irq));

  sac_far_model fm (.clock_in(clock_in), .reset_n_in(reset_n_in), .go_in(go),
    .hold_in(hold), .chan_in(chan), .conversion_start_out(cstart), .adc_raw_out(raw));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Single transfer; waits on hready, however long the slave takes
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask : bus

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
    chk("hresp", hresp, 1'b0);
  endtask : rd

  task automatic wait_busy(input logic v);
    n = 0;
    while (busy !== v && n < 50) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("busy level", busy, v);
  endtask : wait_busy

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    chk("cfg", cfg, 2'b10);
    chk("ref oe", oe, 1'b0);
    rd("status", 32'h04, 32'h2);
    $display("test reset config done");
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    wait_busy(1'b1);
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      chk("hold", hold, 1'b1);
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("busy cycles", 32'(n), 32'(CONV));
    chk("hold after", hold, 1'b0);
    for (int k = 0; k < 8; k++) begin
      rd("result", 32'h10 + 32'(4 * k), {14'h0, expv[k]});
    end
    chk("irq masked", irq, 1'b0);
    rd("int stat", 32'h08, 32'h1);
    $display("test pin conversion done");
    bus(1'b1, 32'h0C, 32'h3);
    bus(1'b1, 32'h00, 32'h1);
    wait_busy(1'b1);
    rd("status busy", 32'h04, 32'hB);
    rd("old result", 32'h18, {14'h0, expv[2]});
    bus(1'b1, 32'h00, 32'h1);
    wait_busy(1'b0);
    chk("irq", irq, 1'b1);
    rd("int stat", 32'h08, 32'h3);
    chk("irq cleared", irq, 1'b0);
    rd("int stat", 32'h08, 32'h0);
    rd("new result", 32'h2C, {14'h0, ~expv[7]});
    for (int k = 0; k < 8; k++) begin
      rd("second set", 32'h10 + 32'(4 * k), {14'h0, ~expv[k]});
    end
    $display("test soft conversion done");
    bus(1'b1, 32'h40, 32'hFFFFFFFF);
    rd("unmapped", 32'h40, 32'h0);
    rd("mask", 32'h0C, 32'h3);
    $display("test address map done");
    span_sel <= 1'b0;
    ref_sel <= 1'b1;
    repeat (4000) @(posedge clock_in);
    bus(1'b1, 32'h00, 32'h2);
    repeat (4) @(posedge clock_in);
    #1;
    chk("cfg", cfg, 2'b01);
    chk("ref oe", oe, 1'b1);
    rd("status", 32'h04, 32'h4);
    $display("test reload done");
    test_done();
  end
endmodule : tb_simultaneous_adc_conversion_control
